// ### cfd_pkg.sv
// Purpose: constants for the diagnostics and filter routing block
// Assumes: apb with 32-bit words, 16-bit registers in the low half
// Notes:   each register takes one aligned word
package cfd_pkg;
    // register byte addresses
    localparam logic [11:0] CFD_OFF_DIAG_DATA    = 12'h000;
    localparam logic [11:0] CFD_OFF_NOM_COUNTS   = 12'h004;
    localparam logic [11:0] CFD_OFF_ERR_FLAGS    = 12'h008;
    localparam logic [11:0] CFD_OFF_CLEAN_COUNT  = 12'h00C;
    localparam logic [11:0] CFD_OFF_ROUTE_LO0    = 12'h010;
    localparam logic [11:0] CFD_OFF_ROUTE_HI0    = 12'h020;
    localparam logic [11:0] CFD_OFF_PAYLOAD_SIZE = 12'h030;
    // register counts and steps
    localparam int CFD_NUM_ROUTE_REGS = 4;
    localparam int CFD_ROUTE_STEP     = 4;
    localparam int CFD_NUM_FILTERS    = 16;
    // reset values
    localparam logic [15:0] CFD_RST_WORD = 16'h0000;
    // flag bit positions
    localparam int CFD_BIT_LEN_MISMATCH = 15;
    localparam int CFD_BIT_ESI          = 14;
    localparam int CFD_BIT_D_CRC        = 13;
    localparam int CFD_BIT_D_STUFF      = 12;
    localparam int CFD_BIT_D_FORM       = 11;
    localparam int CFD_BIT_D_REC        = 9;
    localparam int CFD_BIT_D_DOM        = 8;
    localparam int CFD_BIT_BUSOFF_REC   = 7;
    localparam int CFD_BIT_N_CRC        = 5;
    localparam int CFD_BIT_N_STUFF      = 4;
    localparam int CFD_BIT_N_FORM       = 3;
    localparam int CFD_BIT_N_ACK        = 2;
    localparam int CFD_BIT_N_REC        = 1;
    localparam int CFD_BIT_N_DOM        = 0;
    // implemented flag bits (10 and 6 read as zero)
    localparam logic [15:0] CFD_FLAG_MASK  = 16'hFBBF;
    // route byte layout: enable bit 7, pointer bits 4..0
    localparam logic [7:0]  CFD_ROUTE_MASK = 8'h9F;
    localparam int CFD_ROUTE_EN_BIT = 7;
    // pointer codes
    localparam logic [4:0] CFD_PTR_TXQ      = 5'h00;
    localparam logic [4:0] CFD_PTR_LAST_OBJ = 5'h07;
    // recessive bits per recovery step
    localparam logic [3:0] CFD_RECOVERY_BITS = 4'hB;
endpackage : cfd_pkg

// ### cfd_route_sel.sv
// Purpose: picks the receive object for a filter hit
// Assumes: filter_route holds one route byte per filter
// Notes:   combinational, registered by the parent
`timescale 1ns/100ps
`default_nettype none
module cfd_route_sel (
    // route table
    input  wire logic [127:0] filter_route,
    // hit request
    input  wire logic         hit_valid,
    input  wire logic [3:0]   hit_filter,
    // selection
    output logic              store_valid,
    output logic [2:0]        store_object
);
    import cfd_pkg::*;
    logic [7:0] entry; // route byte of the hit filter

    // only an enabled filter with a legal object pointer stores
    always_comb begin
        entry        = filter_route[hit_filter*8 +: 8];
        store_valid  = hit_valid && entry[CFD_ROUTE_EN_BIT]
                       && entry[4:0] != CFD_PTR_TXQ && entry[4:0] <= CFD_PTR_LAST_OBJ;
        store_object = entry[2:0];
    end
endmodule // cfd_route_sel
`default_nettype wire

// ### cfd_diag_route.sv
// Purpose: bus diagnostic counters, sticky error flags and filter routing
// Assumes: protocol engine gives one-cycle event pulses on pclk
// Notes:   apb slave, zero wait states, pslverr on unmapped addresses
// How it works
// - nominal tx/rx counts share one register
// - dlc above fifo payload sets mismatch
// - received esi bit is recorded
// - data-phase flags mirror nominal ones
// - bus-off then recovery sets a flag
// - crc mismatch sets nominal crc flag
// - six equal stuffed bits set stuff flag
// - bad fixed field sets form flag
// - no acknowledge sets ack flag
// - recessive sent, dominant seen sets flag
// - dominant sent, recessive seen sets flag
// - each 11 recessive bits in recovery
// - 16-bit clean message counter, software rw
// - enable bit gates filter acceptance
// - pointer 1..7 selects receive object
// - four upper route registers, filters 4x+2/3
// - four lower route registers, filters 4x/4x+1
// - separate data-phase tx/rx counts
`timescale 1ns/100ps
`default_nettype none
module cfd_diag_route (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic             pready,
    output logic [31:0]      prdata,
    output logic             pslverr,
    // protocol engine events, one-cycle pulses, and the in_busoff_recovery level
    input  wire logic        ev_data_phase,
    input  wire logic        ev_crc_err,
    input  wire logic        ev_stuff_err,
    input  wire logic        ev_form_err,
    input  wire logic        ev_ack_err,
    input  wire logic        ev_rec_err,
    input  wire logic        ev_dom_err,
    input  wire logic        ev_frame_ok,
    input  wire logic        ev_esi_valid,
    input  wire logic        ev_esi,
    input  wire logic        ev_dlc_valid,
    input  wire logic [3:0]  ev_dlc,
    input  wire logic        ev_busoff_recovered,
    input  wire logic        ev_recessive_bit,
    input  wire logic        ev_dominant_bit,
    input  wire logic        in_busoff_recovery,
    // error count updates from the fault confinement logic
    input  wire logic        cnt_load,
    input  wire logic [7:0]  nom_tx_cnt_in,
    input  wire logic [7:0]  nom_rx_cnt_in,
    input  wire logic [7:0]  dat_tx_cnt_in,
    input  wire logic [7:0]  dat_rx_cnt_in,
    // filter hit from the matcher
    input  wire logic        hit_valid,
    input  wire logic [3:0]  hit_filter,
    // routing result
    output logic             store_valid,
    output logic [2:0]       store_object,
    // current payload size setting
    output logic [2:0]       fifo_payload_size
);
    import cfd_pkg::*;

    // state registers
    logic [7:0]   nominal_tx_error_count;
    logic [7:0]   nominal_rx_error_count;
    logic [7:0]   data_phase_tx_error_count;
    logic [7:0]   data_phase_rx_error_count;
    logic [15:0]  bus_error_flags;
    logic [15:0]  clean_message_counter;
    logic [127:0] filter_route;       // byte f is filter f
    logic [3:0]   recessive_run;      // recessive bits in recovery
    logic [31:0]  rdata_q;
    logic         slverr_q;
    logic         ready_q;
    logic         store_valid_q;
    logic [2:0]   store_object_q;
    logic [2:0]   payload_q;

    // next values
    logic [7:0]   next_nom_tx;
    logic [7:0]   next_nom_rx;
    logic [7:0]   next_dat_tx;
    logic [7:0]   next_dat_rx;
    logic [15:0]  next_flags;
    logic [15:0]  next_clean;
    logic [127:0] next_route;
    logic [3:0]   next_run;
    logic [31:0]  next_rdata;
    logic         next_slverr;
    logic [2:0]   next_payload;
    logic [15:0]  set_bits;           // hardware set requests
    logic [15:0]  wdata16;
    logic [15:0]  wmask16;
    logic         wr_en;
    logic         rd_en;
    logic         sel_valid;
    logic [2:0]   sel_object;
    logic         recovery_step;

    // dlc code to payload byte count
    function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
        case (dlc)
            4'h9:    dlc_bytes = 7'd12;
            4'hA:    dlc_bytes = 7'd16;
            4'hB:    dlc_bytes = 7'd20;
            4'hC:    dlc_bytes = 7'd24;
            4'hD:    dlc_bytes = 7'd32;
            4'hE:    dlc_bytes = 7'd48;
            4'hF:    dlc_bytes = 7'd64;
            default: dlc_bytes = (dlc > 4'h8) ? 7'd8 : {3'b000, dlc};
        endcase
    endfunction

    // payload size code to byte count
    function automatic logic [6:0] size_bytes(input logic [2:0] code);
        case (code)
            3'h0:    size_bytes = 7'd8;
            3'h1:    size_bytes = 7'd12;
            3'h2:    size_bytes = 7'd16;
            3'h3:    size_bytes = 7'd20;
            3'h4:    size_bytes = 7'd24;
            3'h5:    size_bytes = 7'd32;
            3'h6:    size_bytes = 7'd48;
            default: size_bytes = 7'd64;
        endcase
    endfunction

    // address match used by several registers
    function automatic logic hit_addr(input logic [11:0] a, input logic [11:0] off);
        hit_addr = (a == off);
    endfunction

    // route lookup for the hit filter
    cfd_route_sel u_route_sel (
        .filter_route (filter_route),
        .hit_valid    (hit_valid),
        .hit_filter   (hit_filter),
        .store_valid  (sel_valid),
        .store_object (sel_object)
    );

    // bus qualifiers: writes land in the access phase
    always_comb begin
        wr_en   = psel && penable && pwrite;
        rd_en   = psel && !penable && !pwrite;
        wdata16 = pwdata[15:0];
        wmask16 = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    // recovery sequence: count recessive bits, dominant restarts
    always_comb begin
        next_run      = recessive_run;
        recovery_step = 1'b0;
        if (!in_busoff_recovery || ev_dominant_bit) begin
            next_run = 4'h0;
        end else if (ev_recessive_bit) begin
            if (recessive_run == CFD_RECOVERY_BITS - 4'h1) begin
                next_run      = 4'h0;
                recovery_step = 1'b1;
            end else begin
                next_run = recessive_run + 4'h1;
            end
        end
    end

    // flag set requests from the protocol engine
    always_comb begin
        set_bits = 16'h0000;
        set_bits[CFD_BIT_LEN_MISMATCH] = ev_dlc_valid
            && (dlc_bytes(ev_dlc) > size_bytes(payload_q));
        set_bits[CFD_BIT_D_CRC]   = ev_data_phase && ev_crc_err;
        set_bits[CFD_BIT_D_STUFF] = ev_data_phase && ev_stuff_err;
        set_bits[CFD_BIT_D_FORM]  = ev_data_phase && ev_form_err;
        set_bits[CFD_BIT_D_REC]   = ev_data_phase && ev_rec_err;
        set_bits[CFD_BIT_D_DOM]   = ev_data_phase && ev_dom_err;
        set_bits[CFD_BIT_BUSOFF_REC] = ev_busoff_recovered;
        set_bits[CFD_BIT_N_CRC]   = !ev_data_phase && ev_crc_err;
        set_bits[CFD_BIT_N_STUFF] = !ev_data_phase && ev_stuff_err;
        set_bits[CFD_BIT_N_FORM]  = !ev_data_phase && ev_form_err;
        set_bits[CFD_BIT_N_ACK]   = ev_ack_err;
        set_bits[CFD_BIT_N_REC]   = !ev_data_phase && ev_rec_err;
        set_bits[CFD_BIT_N_DOM]   = (!ev_data_phase && ev_dom_err)
                                    || recovery_step;
    end

    // register file next state; hardware set beats software clear
    always_comb begin
        next_nom_tx  = nominal_tx_error_count;
        next_nom_rx  = nominal_rx_error_count;
        next_dat_tx  = data_phase_tx_error_count;
        next_dat_rx  = data_phase_rx_error_count;
        next_flags   = bus_error_flags;
        next_clean   = clean_message_counter;
        next_route   = filter_route;
        next_payload = payload_q;
        // software writes
        if (wr_en && hit_addr(paddr, CFD_OFF_NOM_COUNTS)) begin
            if (pstrb[1]) next_nom_tx = wdata16[15:8];
            if (pstrb[0]) next_nom_rx = wdata16[7:0];
        end
        if (wr_en && hit_addr(paddr, CFD_OFF_DIAG_DATA)) begin
            if (pstrb[1]) next_dat_tx = wdata16[15:8];
            if (pstrb[0]) next_dat_rx = wdata16[7:0];
        end
        if (wr_en && hit_addr(paddr, CFD_OFF_ERR_FLAGS)) begin
            // written zero clears, written one leaves the flag
            next_flags = bus_error_flags & ~(wmask16 & ~wdata16);
        end
        if (wr_en && hit_addr(paddr, CFD_OFF_CLEAN_COUNT)) begin
            next_clean = (clean_message_counter & ~wmask16)
                         | (wdata16 & wmask16);
        end else if (ev_frame_ok) begin
            next_clean = clean_message_counter + 16'h0001;
        end
        if (wr_en && hit_addr(paddr, CFD_OFF_PAYLOAD_SIZE) && pstrb[0]) begin
            next_payload = pwdata[2:0];
        end
        for (int r = 0; r < CFD_NUM_ROUTE_REGS; r++) begin
            // lower register r: filters 4r and 4r+1
            if (wr_en && hit_addr(paddr, CFD_OFF_ROUTE_LO0
                    + 12'(r * CFD_ROUTE_STEP))) begin
                if (pstrb[0]) next_route[(4*r)*8 +: 8] =
                    pwdata[7:0] & CFD_ROUTE_MASK;
                if (pstrb[1]) next_route[(4*r+1)*8 +: 8] =
                    pwdata[15:8] & CFD_ROUTE_MASK;
            end
            // upper register r: filters 4r+2 and 4r+3
            if (wr_en && hit_addr(paddr, CFD_OFF_ROUTE_HI0
                    + 12'(r * CFD_ROUTE_STEP))) begin
                if (pstrb[0]) next_route[(4*r+2)*8 +: 8] =
                    pwdata[7:0] & CFD_ROUTE_MASK;
                if (pstrb[1]) next_route[(4*r+3)*8 +: 8] =
                    pwdata[15:8] & CFD_ROUTE_MASK;
            end
        end
        // fault confinement reloads counts; it wins over software
        if (cnt_load) begin
            next_nom_tx = nom_tx_cnt_in;
            next_nom_rx = nom_rx_cnt_in;
            next_dat_tx = dat_tx_cnt_in;
            next_dat_rx = dat_rx_cnt_in;
        end
        // esi follows each received fd frame
        if (ev_esi_valid) begin
            next_flags[CFD_BIT_ESI] = ev_esi;
        end
        next_flags = (next_flags | set_bits) & CFD_FLAG_MASK;
    end

    // read mux, sampled in the setup phase
    always_comb begin
        next_rdata  = 32'h0000_0000;
        next_slverr = 1'b0;
        if (hit_addr(paddr, CFD_OFF_NOM_COUNTS)) begin
            next_rdata[15:0] = {nominal_tx_error_count, nominal_rx_error_count};
        end else if (hit_addr(paddr, CFD_OFF_DIAG_DATA)) begin
            next_rdata[15:0] = {data_phase_tx_error_count, data_phase_rx_error_count};
        end else if (hit_addr(paddr, CFD_OFF_ERR_FLAGS)) begin
            next_rdata[15:0] = bus_error_flags;
        end else if (hit_addr(paddr, CFD_OFF_CLEAN_COUNT)) begin
            next_rdata[15:0] = clean_message_counter;
        end else if (hit_addr(paddr, CFD_OFF_PAYLOAD_SIZE)) begin
            next_rdata[2:0] = payload_q;
        end else if (paddr >= CFD_OFF_ROUTE_LO0 && paddr < CFD_OFF_PAYLOAD_SIZE
                     && paddr[1:0] == 2'b00 && paddr[3:2] != 2'b00 ? 1'b0 : 1'b0) begin
            next_rdata = 32'h0000_0000;
        end else begin
            next_slverr = 1'b1;
        end
        // route registers decoded by loop
        for (int r = 0; r < CFD_NUM_ROUTE_REGS; r++) begin
            if (hit_addr(paddr, CFD_OFF_ROUTE_LO0 + 12'(r * CFD_ROUTE_STEP))) begin
                next_rdata[15:0] = filter_route[(4*r)*8 +: 16];
                next_slverr      = 1'b0;
            end
            if (hit_addr(paddr, CFD_OFF_ROUTE_HI0 + 12'(r * CFD_ROUTE_STEP))) begin
                next_rdata[15:0] = filter_route[(4*r+2)*8 +: 16];
                next_slverr      = 1'b0;
            end
        end
        if (!rd_en && !(psel && !penable)) begin
            next_slverr = 1'b0;
        end
    end

    // registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            nominal_tx_error_count    <= CFD_RST_WORD[7:0];
            nominal_rx_error_count    <= CFD_RST_WORD[7:0];
            data_phase_tx_error_count <= CFD_RST_WORD[7:0];
            data_phase_rx_error_count <= CFD_RST_WORD[7:0];
            bus_error_flags           <= CFD_RST_WORD;
            clean_message_counter     <= CFD_RST_WORD;
            filter_route              <= '0;
            recessive_run             <= 4'h0;
            rdata_q                   <= 32'h0000_0000;
            slverr_q                  <= 1'b0;
            ready_q                   <= 1'b0;
            store_valid_q             <= 1'b0;
            store_object_q            <= 3'h0;
            payload_q                 <= 3'h0;
        end else begin
            nominal_tx_error_count    <= next_nom_tx;
            nominal_rx_error_count    <= next_nom_rx;
            data_phase_tx_error_count <= next_dat_tx;
            data_phase_rx_error_count <= next_dat_rx;
            bus_error_flags           <= next_flags;
            clean_message_counter     <= next_clean;
            filter_route              <= next_route;
            recessive_run             <= next_run;
            // answer registered in setup, shown in access phase
            if (psel && !penable) begin
                rdata_q  <= next_rdata;
            end
            slverr_q                  <= next_slverr;   // high only after a setup
            ready_q                   <= psel && !penable;
            store_valid_q             <= sel_valid;
            store_object_q            <= sel_object;
            payload_q                 <= next_payload;
        end
    end

    // outputs straight from flip-flops
    always_comb begin
        pready            = ready_q;
        prdata            = rdata_q;
        pslverr           = slverr_q;
        store_valid       = store_valid_q;
        store_object      = store_object_q;
        fifo_payload_size = payload_q;
    end
endmodule // cfd_diag_route
`default_nettype wire

// ### cfd_diag_checker.sv
// Purpose: concurrent checks on the apb side and the routing output
// Assumes: one-cycle apb answer, pulses on pclk
// Notes:   attached to every instance by the bind at the foot
`timescale 1ns/100ps
`default_nettype none
module cfd_diag_checker
    import cfd_pkg::*;
(
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic [31:0] prdata,
    // routing
    input wire logic        hit_valid,
    input wire logic        store_valid
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // setup phase of a transfer
    sequence s_setup;
        psel && !penable;
    endsequence
    // read answer at the access edge
    sequence s_read;
        pready && !pwrite;
    endsequence
    AST_PREADY_NEXT: assert property (s_setup |=> pready && penable)
        else $error("no answer one cycle after setup");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready stood longer than one cycle");
    AST_ERR_UNMAPPED: assert property (pready && paddr > CFD_OFF_PAYLOAD_SIZE |-> pslverr)
        else $error("unmapped access not refused");
    AST_ERR_DATA: assert property (s_read ##0 pslverr |-> prdata == 32'h0000_0000)
        else $error("refused read returned data");
    AST_MAPPED_OK: assert property (pready && paddr[1:0] == 2'b00 &&
        paddr <= CFD_OFF_PAYLOAD_SIZE |-> !pslverr) else $error("mapped access refused");
    AST_UPPER_ZERO: assert property (s_read |-> prdata[31:16] == 16'h0000)
        else $error("upper half of read data not zero");
    AST_FLAG_RSVD: assert property (s_read ##0 paddr == CFD_OFF_ERR_FLAGS
        |-> !prdata[10] && !prdata[6]) else $error("unused flag bits read set");
    AST_ROUTE_RSVD: assert property (s_read ##0 paddr[11:4] inside {8'h01, 8'h02}
        |-> prdata[14:13] == 2'b00 && prdata[6:5] == 2'b00) else $error("route gap bits set");
    AST_STORE_CAUSE: assert property (store_valid |-> $past(hit_valid))
        else $error("store without a hit one cycle before");
    // refused transfer seen at least once
    cover property (s_setup ##1 pslverr);
endmodule // cfd_diag_checker
bind cfd_diag_route cfd_diag_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pready, .pslverr, .prdata, .hit_valid, .store_valid);
`default_nettype wire

// ### cfd_bus_node.sv
// Purpose: stands for the bus and protocol engine, giving event pulses
// Assumes: driven from the bench by calls to pulse
// Notes:   dlc shows the inverse of its last value once released
`timescale 1ns/100ps
`default_nettype none
module cfd_bus_node (
    // clock
    input wire logic  pclk,
    // event lines and dlc
    output logic [13:0] ev,
    output logic [3:0]  dlc
);
    // quiet at time zero
    initial begin
        ev = '0;
        dlc = '0;
    end
    // one-cycle pulse of the events in m, with dlc d beside it
    task automatic pulse(input logic [13:0] m, input logic [3:0] d);
        @(posedge pclk);
        ev <= m;
        dlc <= d;
        @(posedge pclk);
        ev <= '0;
        dlc <= ~d;
    endtask
endmodule // cfd_bus_node
`default_nettype wire

// ### can_fd_bus_diag_and_filter_route_tb.sv
// Purpose: self-checking bench for the diagnostics and routing block
// Assumes: apb answer follows setup by one cycle, events are pulses
// Notes:   register rows first, then flags, recovery, counters, routing
`timescale 1ns/100ps
`default_nettype none
module can_fd_bus_diag_and_filter_route_tb;
    import cfd_pkg::*;
    // register row: address, write value, expected read, expected refusal
    typedef struct packed {logic [11:0] a; logic [15:0] w, r; logic e;} cfd_row_t;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, err;
    logic cnt_load = 0, hit_valid = 0, in_busoff_recovery = 0;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, cnt_in = '0, rd;
    logic [3:0]  hit_filter = '0, ev_dlc;
    logic        pready, pslverr, store_valid;
    logic [31:0] prdata;
    logic [2:0]  store_object, fifo_payload_size;
    logic [13:0] ev;
    int          n_fail = 0, comparisons = 0;
    cfd_row_t    rows [8] = '{'{CFD_OFF_DIAG_DATA, 16'h1234, 16'h1234, 0},
        '{CFD_OFF_NOM_COUNTS, 16'hA55A, 16'hA55A, 0}, '{CFD_OFF_ERR_FLAGS, 16'hFFFF, 0, 0},
        '{CFD_OFF_CLEAN_COUNT, 16'hBEEF, 16'hBEEF, 0}, '{12'h010, 16'hE7E7, 16'h8787, 0},
        '{12'h02C, 16'hE7E7, 16'h8787, 0}, '{12'h030, 16'h0007, 16'h0007, 0},
        '{12'h040, 16'hFFFF, 16'h0000, 1}};
    // flag events and the bit each must set
    logic [13:0] fm [12] = '{14'h0002, 14'h0004, 14'h0008, 14'h0010, 14'h0020, 14'h0040,
        14'h0003, 14'h0005, 14'h0009, 14'h0021, 14'h0041, 14'h0800};
    int          fb [12] = '{5, 4, 3, 2, 1, 0, 13, 12, 11, 9, 8, 7};
    // clock at 40 MHz
    always #12.5 pclk = ~pclk;
    cfd_bus_node node (.pclk, .ev, .dlc(ev_dlc));
    cfd_diag_route u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .pstrb(4'hF), .pready, .prdata, .pslverr, .ev_data_phase(ev[0]), .ev_crc_err(ev[1]),
        .ev_stuff_err(ev[2]), .ev_form_err(ev[3]), .ev_ack_err(ev[4]), .ev_rec_err(ev[5]),
        .ev_dom_err(ev[6]), .ev_frame_ok(ev[7]), .ev_esi_valid(ev[8]), .ev_esi(ev[9]),
        .ev_dlc_valid(ev[10]), .ev_dlc, .ev_busoff_recovered(ev[11]),
        .ev_recessive_bit(ev[12]), .ev_dominant_bit(ev[13]), .in_busoff_recovery, .cnt_load,
        .nom_tx_cnt_in(cnt_in[31:24]), .nom_rx_cnt_in(cnt_in[23:16]),
        .dat_tx_cnt_in(cnt_in[15:8]), .dat_rx_cnt_in(cnt_in[7:0]), .hit_valid, .hit_filter,
        .store_valid, .store_object, .fifo_payload_size);
    // compare and count
    task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one apb transfer, held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // wait for the answer; only the watchdog ends a hang
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    // read and compare a register
    task automatic rdc(input logic [11:0] a, input logic [15:0] x);
        apb(0, a, '0);
        chk("register", rd, {16'h0000, x});
    endtask
    // one filter hit and the routing result
    task automatic hit(input logic [3:0] f, input logic [2:0] obj, input logic v);
        @(posedge pclk);
        hit_valid <= 1;
        hit_filter <= f;
        @(posedge pclk);
        hit_valid <= 0;
        hit_filter <= ~f;
        #1 chk("store_valid", store_valid, v);
        if (v) chk("store_object", store_object, obj);
    endtask
    // counts and verdict
    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // cut a hang short
    initial begin
        #250_000;
        n_fail++;
        results();
    end
    // main sequence
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1;
        foreach (rows[i]) begin
            rdc(rows[i].a, 16'h0000);
            apb(1, rows[i].a, {16'h0000, rows[i].w});
            rdc(rows[i].a, rows[i].r);
            chk("pslverr", err, rows[i].e);
        end
        chk("fifo_payload_size", fifo_payload_size, 32'h0000_0007);
        $display("register rows done");
        foreach (fm[i]) begin
            node.pulse(fm[i], 4'h0);
            rdc(CFD_OFF_ERR_FLAGS, 16'h0001 << fb[i]);
            rdc(CFD_OFF_ERR_FLAGS, 16'h0001 << fb[i]);
            apb(1, CFD_OFF_ERR_FLAGS, '0);
            rdc(CFD_OFF_ERR_FLAGS, 16'h0000);
        end
        node.pulse(14'h0300, 4'h0);
        rdc(CFD_OFF_ERR_FLAGS, 16'h4000);
        node.pulse(14'h0100, 4'h0);
        rdc(CFD_OFF_ERR_FLAGS, 16'h0000);
        apb(1, CFD_OFF_PAYLOAD_SIZE, '0);
        node.pulse(14'h0400, 4'h8);
        rdc(CFD_OFF_ERR_FLAGS, 16'h0000);
        node.pulse(14'h0400, 4'hF);
        rdc(CFD_OFF_ERR_FLAGS, 16'h8000);
        apb(1, CFD_OFF_ERR_FLAGS, '0);
        $display("flag tests done");
        in_busoff_recovery <= 1;
        for (int i = 0; i < 16; i++) node.pulse(i == 5 ? 14'h2000 : 14'h1000, 4'h0);
        rdc(CFD_OFF_ERR_FLAGS, 16'h0000);
        node.pulse(14'h1000, 4'h0);
        rdc(CFD_OFF_ERR_FLAGS, 16'h0001);
        in_busoff_recovery <= 0;
        $display("recovery test done");
        apb(1, CFD_OFF_CLEAN_COUNT, 32'h0000_FFFF);
        node.pulse(14'h0080, 4'h0);
        rdc(CFD_OFF_CLEAN_COUNT, 16'h0000);
        node.pulse(14'h0080, 4'h0);
        rdc(CFD_OFF_CLEAN_COUNT, 16'h0001);
        @(posedge pclk);
        cnt_in <= 32'h1122_3344;
        cnt_load <= 1;
        @(posedge pclk);
        cnt_load <= 0;
        rdc(CFD_OFF_NOM_COUNTS, 16'h1122);
        rdc(CFD_OFF_DIAG_DATA, 16'h3344);
        $display("counter tests done");
        for (int p = 1; p < 8; p++) begin
            // filter 6 enabled, filter 7 disabled, both at legal pointer p
            apb(1, 12'h024, {16'h0000, 5'h00, p[2:0], 5'h10, p[2:0]});
            hit(4'd6, p[2:0], 1);
            hit(4'd7, p[2:0], 0);
        end
        apb(1, 12'h018, 32'h0000_8503);
        hit(4'd9, 3'd5, 1);
        hit(4'd8, 3'd3, 0);
        $display("routing tests done");
        @(posedge pclk);
        presetn <= 0;
        repeat (2) @(posedge pclk);
        presetn <= 1;
        rdc(CFD_OFF_NOM_COUNTS, 16'h0000);
        rdc(12'h018, 16'h0000);
        $display("second reset test done");
        results();
    end
endmodule // can_fd_bus_diag_and_filter_route_tb
`default_nettype wire
